// ==== ivf_core_model.sv ====
`timescale 1ns/1ps
module ivf_core_model (
  input  wire logic                       sys_clk,
  input  wire logic [ivf_pkg::VAB_W-1:0]  vector_address_bus,
  input  wire ivf_pkg::ivf_src_t          vab_src,
  output logic                            win_valid,
  output logic      [ivf_pkg::VSEL_W-1:0] win_vector,
  output logic      [ivf_pkg::PRIO_W-1:0] win_level
);
  initial begin
    win_valid = 1'b0;
    win_vector = 7'h00;
    win_level = 2'h0;
  end
  task automatic take(input logic [6:0] vec, input logic [1:0] lvl, input int hold,
                      output logic [20:0] va, output ivf_pkg::ivf_src_t src);
    win_valid <= 1'b1;
    win_vector <= vec;
    win_level <= lvl;
    repeat (2 + hold) @(posedge sys_clk);
    va = vector_address_bus;
    src = vab_src;
  endtask : take
  // released win_vector and win_level lines toggle so stale values are never trusted; win_valid drops low
  task automatic idle();
    win_valid <= 1'b0;
    win_vector <= ~win_vector;
    win_level <= ~win_level;
  endtask : idle
endmodule : ivf_core_model

// ==== ivf_pkg.sv ====
package ivf_pkg;

  // bus and register widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 10;

  // register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRIO9     = 10'h009;
  localparam logic [IDX_W-1:0] IDX_VBASE     = 10'h00a;
  localparam logic [IDX_W-1:0] IDX_F0SEL     = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_F0LO      = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_F0HI      = 10'h00d;
  localparam logic [IDX_W-1:0] IDX_F1SEL     = 10'h00e;
  localparam logic [IDX_W-1:0] IDX_F1LO      = 10'h00f;
  localparam logic [IDX_W-1:0] IDX_F1HI      = 10'h010;
  localparam logic [IDX_W-1:0] IDX_PEND0     = 10'h011;
  localparam logic [IDX_W-1:0] IDX_PEND_LAST = 10'h016;
  localparam logic [IDX_W-1:0] IDX_STAT      = 10'h020;
  localparam logic [IDX_W-1:0] IDX_MASK      = 10'h021;

  // priority field layout
  localparam int PRIO_W           = 2;
  localparam int CONV_NUM         = 4;
  localparam int CONV_A_LIMIT_LSB = 6;
  localparam int CONV_B_LIMIT_LSB = 4;
  localparam int CONV_A_DONE_LSB  = 2;
  localparam int CONV_B_DONE_LSB  = 0;
  localparam logic [PRIO_W-1:0] PRIO_OFF  = 2'h0;
  localparam logic [PRIO_W-1:0] LEVEL_TOP = 2'h2;

  // vector address layout
  localparam int VBASE_W   = 13;
  localparam int VSEL_W    = 7;
  localparam int FLO_W     = 16;
  localparam int FHI_W     = 5;
  localparam int VAB_W     = 21;
  localparam int VEC_LOW_W = 8;

  // reset values
  localparam logic [PRIO_W-1:0]  PRIO_RST  = 2'h0;
  localparam logic [VBASE_W-1:0] VBASE_RST = 13'h0000;
  localparam logic [VSEL_W-1:0]  VSEL_RST  = 7'h00;
  localparam logic [FLO_W-1:0]   FLO_RST   = 16'h0000;
  localparam logic [FHI_W-1:0]   FHI_RST   = 5'h00;

  // pending map: bit i of pending register k is vector 16k+1+i
  localparam int VEC_FIRST    = 2;
  localparam int VEC_LAST     = 81;
  localparam int PEND_REGS    = 6;
  localparam int PEND_VEC_TOP = 96;

  // event status bits
  localparam int EV_W     = 3;
  localparam int EV_TABLE = 0;
  localparam int EV_FAST0 = 1;
  localparam int EV_FAST1 = 2;

  typedef struct packed {
    logic              valid;
    logic [PRIO_W-1:0] level;
  } ivf_conv_req_t;

  typedef struct packed {
    logic [VSEL_W-1:0] vsel;
    logic [FHI_W-1:0]  hi;
    logic [FLO_W-1:0]  lo;
  } ivf_fast_cfg_t;

  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_TABLE = 2'b01,
    SRC_FAST0 = 2'b10,
    SRC_FAST1 = 2'b11
  } ivf_src_t;

endpackage : ivf_pkg

// ==== ivf_vector_ctrl.sv ====
`timescale 1ns/1ps
module ivf_vector_ctrl #(
  parameter int VEC_LAST = ivf_pkg::VEC_LAST
) (
  input  wire logic                              sys_clk,
  input  wire logic                              resetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ivf_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [ivf_pkg::DATA_W-1:0]        pwdata,
  output logic      [ivf_pkg::DATA_W-1:0]        prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic [ivf_pkg::CONV_NUM-1:0]      conv_src_req,
  output ivf_pkg::ivf_conv_req_t [ivf_pkg::CONV_NUM-1:0] conv_req,
  input  wire logic [VEC_LAST:ivf_pkg::VEC_FIRST] irq_req,
  input  wire logic                              win_valid,
  input  wire logic [ivf_pkg::VSEL_W-1:0]        win_vector,
  input  wire logic [ivf_pkg::PRIO_W-1:0]        win_level,
  output logic      [ivf_pkg::VAB_W-1:0]         vector_address_bus,
  output logic                                   vab_valid,
  output ivf_pkg::ivf_src_t                      vab_src,
  output logic                                   irq
);

  logic                                rst_meta_r;
  logic                                rst_n_r;
  logic [ivf_pkg::REG_W-1:0]           prio9_r;
  logic [ivf_pkg::VBASE_W-1:0]         vbase_r;
  ivf_pkg::ivf_fast_cfg_t              fast0_r;
  ivf_pkg::ivf_fast_cfg_t              fast1_r;
  logic [VEC_LAST:ivf_pkg::VEC_FIRST]  req_r;
  logic [ivf_pkg::EV_W-1:0]            status_r;
  logic [ivf_pkg::EV_W-1:0]            mask_r;
  logic [ivf_pkg::DATA_W-1:0]          prdata_r;
  logic                                pready_r;
  logic                                pslverr_r;
  logic [ivf_pkg::VAB_W-1:0]           vab_r;
  logic                                vab_valid_r;
  ivf_pkg::ivf_src_t                   vab_src_r;
  logic                                irq_r;
  ivf_pkg::ivf_conv_req_t [ivf_pkg::CONV_NUM-1:0] conv_req_r;

  logic [ivf_pkg::IDX_W-1:0]           idx;
  logic                                setup;
  logic                                wr_en;
  logic [ivf_pkg::PEND_VEC_TOP:1]      pend_n;
  logic [ivf_pkg::DATA_W-1:0]          rd_nxt;
  logic                                err_nxt;
  ivf_pkg::ivf_src_t                   src_nxt;
  logic [ivf_pkg::VAB_W-1:0]           vab_nxt;
  logic [ivf_pkg::EV_W-1:0]            ev;
  logic [ivf_pkg::EV_W-1:0]            status_nxt;
  logic                                fast0_hit;
  logic                                fast1_hit;
  logic                                stat_clr;
  logic                                mask_wr;

  // decode one converter priority field into an arbiter request
  function automatic ivf_pkg::ivf_conv_req_t prio_decode(
    input logic [ivf_pkg::PRIO_W-1:0] field,
    input logic                       req
  );
    ivf_pkg::ivf_conv_req_t r;
    r.valid = req && (field != ivf_pkg::PRIO_OFF);
    r.level = (field == ivf_pkg::PRIO_OFF) ? ivf_pkg::PRIO_OFF
                                           : ivf_pkg::PRIO_W'(field - 2'h1);
    return r;
  endfunction : prio_decode

  // request line of a vector number, zero outside the implemented range
  function automatic logic req_at(
    input logic [VEC_LAST:ivf_pkg::VEC_FIRST] reqs,
    input logic [ivf_pkg::VSEL_W-1:0]         vec
  );
    logic hit;
    hit = 1'b0;
    for (int i = ivf_pkg::VEC_FIRST; i <= VEC_LAST; i++) begin
      if (vec == ivf_pkg::VSEL_W'(i)) begin
        hit = reqs[i];
      end
    end
    return hit;
  endfunction : req_at

  // 21-bit fast service address from its two halves
  function automatic logic [ivf_pkg::VAB_W-1:0] fast_addr(
    input ivf_pkg::ivf_fast_cfg_t cfg
  );
    return {cfg.hi, cfg.lo};
  endfunction : fast_addr

  // a fast channel takes over for any top-level winner while the line of its own vsel vector is pending
  function automatic logic fast_hit(
    input ivf_pkg::ivf_fast_cfg_t             cfg,
    input logic [VEC_LAST:ivf_pkg::VEC_FIRST] reqs,
    input logic [ivf_pkg::PRIO_W-1:0]         lvl
  );
    return (lvl == ivf_pkg::LEVEL_TOP) && req_at(reqs, cfg.vsel);
  endfunction : fast_hit

  // write strobe of one register index
  function automatic logic reg_wr(
    input logic                      en,
    input logic [ivf_pkg::IDX_W-1:0] at,
    input logic [ivf_pkg::IDX_W-1:0] target
  );
    return en && (at == target);
  endfunction : reg_wr

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  assign idx   = paddr[ivf_pkg::ADDR_W-1:2];
  assign setup = psel && !penable && !pready_r;
  assign wr_en = psel && penable && pready_r && pwrite && !pslverr_r;

  assign fast0_hit = fast_hit(fast0_r, req_r, win_level);
  assign fast1_hit = fast_hit(fast1_r, req_r, win_level);
  assign stat_clr  = reg_wr(wr_en, idx, ivf_pkg::IDX_STAT);
  assign mask_wr   = reg_wr(wr_en, idx, ivf_pkg::IDX_MASK);

  // active-low pending view; unimplemented vectors read as not pending
  always_comb begin
    pend_n = '1;
    for (int i = ivf_pkg::VEC_FIRST; i <= VEC_LAST; i++) begin
      pend_n[i] = !req_r[i];
    end
  end

  // read data and unmapped check, evaluated in the setup cycle
  always_comb begin
    int k;
    k       = 0;
    rd_nxt  = '0;
    err_nxt = 1'b0;
    if (idx == ivf_pkg::IDX_PRIO9) begin
      rd_nxt[7:0] = prio9_r[7:0];
    end else if (idx == ivf_pkg::IDX_VBASE) begin
      rd_nxt[ivf_pkg::VBASE_W-1:0] = vbase_r;
    end else if (idx == ivf_pkg::IDX_F0SEL) begin
      rd_nxt[ivf_pkg::VSEL_W-1:0] = fast0_r.vsel;
    end else if (idx == ivf_pkg::IDX_F0LO) begin
      rd_nxt[ivf_pkg::FLO_W-1:0] = fast0_r.lo;
    end else if (idx == ivf_pkg::IDX_F0HI) begin
      rd_nxt[ivf_pkg::FHI_W-1:0] = fast0_r.hi;
    end else if (idx == ivf_pkg::IDX_F1SEL) begin
      rd_nxt[ivf_pkg::VSEL_W-1:0] = fast1_r.vsel;
    end else if (idx == ivf_pkg::IDX_F1LO) begin
      rd_nxt[ivf_pkg::FLO_W-1:0] = fast1_r.lo;
    end else if (idx == ivf_pkg::IDX_F1HI) begin
      rd_nxt[ivf_pkg::FHI_W-1:0] = fast1_r.hi;
    end else if (idx >= ivf_pkg::IDX_PEND0 && idx <= ivf_pkg::IDX_PEND_LAST) begin
      k = int'(idx - ivf_pkg::IDX_PEND0);
      rd_nxt[ivf_pkg::REG_W-1:0] = pend_n[k*ivf_pkg::REG_W+1 +: ivf_pkg::REG_W];
    end else if (idx == ivf_pkg::IDX_STAT) begin
      rd_nxt[ivf_pkg::EV_W-1:0] = status_r;
    end else if (idx == ivf_pkg::IDX_MASK) begin
      rd_nxt[ivf_pkg::EV_W-1:0] = mask_r;
    end else begin
      err_nxt = 1'b1;
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && err_nxt;
      if (setup && !pwrite && !err_nxt) begin
        prdata_r <= rd_nxt;
      end else if (!setup) begin
        prdata_r <= '0;
      end
    end
  end

  // converter priority register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prio9_r <= {ivf_pkg::REG_W{1'b0}} | {8'h00,
                 ivf_pkg::PRIO_RST, ivf_pkg::PRIO_RST, ivf_pkg::PRIO_RST, ivf_pkg::PRIO_RST};
    end else if (reg_wr(wr_en, idx, ivf_pkg::IDX_PRIO9)) begin
      prio9_r <= {8'h00, pwdata[7:0]};
    end
  end

  // vector base register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      vbase_r <= ivf_pkg::VBASE_RST;
    end else if (reg_wr(wr_en, idx, ivf_pkg::IDX_VBASE)) begin
      vbase_r <= pwdata[ivf_pkg::VBASE_W-1:0];
    end
  end

  // fast channel 0 configuration
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fast0_r.vsel <= ivf_pkg::VSEL_RST;
      fast0_r.hi   <= ivf_pkg::FHI_RST;
      fast0_r.lo   <= ivf_pkg::FLO_RST;
    end else if (wr_en) begin
      if (idx == ivf_pkg::IDX_F0SEL) begin
        fast0_r.vsel <= pwdata[ivf_pkg::VSEL_W-1:0];
      end
      if (idx == ivf_pkg::IDX_F0LO) begin
        fast0_r.lo <= pwdata[ivf_pkg::FLO_W-1:0];
      end
      if (idx == ivf_pkg::IDX_F0HI) begin
        fast0_r.hi <= pwdata[ivf_pkg::FHI_W-1:0];
      end
    end
  end

  // fast channel 1 configuration
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fast1_r.vsel <= ivf_pkg::VSEL_RST;
      fast1_r.hi   <= ivf_pkg::FHI_RST;
      fast1_r.lo   <= ivf_pkg::FLO_RST;
    end else if (wr_en) begin
      if (idx == ivf_pkg::IDX_F1SEL) begin
        fast1_r.vsel <= pwdata[ivf_pkg::VSEL_W-1:0];
      end
      if (idx == ivf_pkg::IDX_F1LO) begin
        fast1_r.lo <= pwdata[ivf_pkg::FLO_W-1:0];
      end
      if (idx == ivf_pkg::IDX_F1HI) begin
        fast1_r.hi <= pwdata[ivf_pkg::FHI_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      req_r <= '0;
    end else begin
      req_r <= irq_req;
    end
  end

  // converter requests toward the arbiter
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_req_r <= '0;
    end else begin
      conv_req_r[3] <= prio_decode(prio9_r[ivf_pkg::CONV_A_LIMIT_LSB +: ivf_pkg::PRIO_W],
                                   conv_src_req[3]);
      conv_req_r[2] <= prio_decode(prio9_r[ivf_pkg::CONV_B_LIMIT_LSB +: ivf_pkg::PRIO_W],
                                   conv_src_req[2]);
      conv_req_r[1] <= prio_decode(prio9_r[ivf_pkg::CONV_A_DONE_LSB +: ivf_pkg::PRIO_W],
                                   conv_src_req[1]);
      conv_req_r[0] <= prio_decode(prio9_r[ivf_pkg::CONV_B_DONE_LSB +: ivf_pkg::PRIO_W],
                                   conv_src_req[0]);
    end
  end

  // source selection for the vector address
  always_comb begin
    src_nxt = ivf_pkg::SRC_NONE;
    vab_nxt = '0;
    if (win_valid) begin
      // fast vectors rely on level 2 programming
      if (fast0_hit) begin
        src_nxt = ivf_pkg::SRC_FAST0;
        vab_nxt = fast_addr(fast0_r);
      end else if (fast1_hit) begin
        src_nxt = ivf_pkg::SRC_FAST1;
        vab_nxt = fast_addr(fast1_r);
      end else begin
        src_nxt = ivf_pkg::SRC_TABLE;
        vab_nxt = {vbase_r, win_vector, 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      vab_r       <= '0;
      vab_valid_r <= 1'b0;
      vab_src_r   <= ivf_pkg::SRC_NONE;
    end else begin
      vab_r       <= vab_nxt;
      vab_valid_r <= win_valid;
      vab_src_r   <= src_nxt;
    end
  end

  // events: a new or changed selection
  always_comb begin
    ev = '0;
    if (src_nxt != vab_src_r || (win_valid && !vab_valid_r)) begin
      ev[ivf_pkg::EV_TABLE] = (src_nxt == ivf_pkg::SRC_TABLE);
      ev[ivf_pkg::EV_FAST0] = (src_nxt == ivf_pkg::SRC_FAST0);
      ev[ivf_pkg::EV_FAST1] = (src_nxt == ivf_pkg::SRC_FAST1);
    end
    status_nxt = status_r;
    if (stat_clr) begin
      status_nxt = status_nxt & ~pwdata[ivf_pkg::EV_W-1:0];
    end
    // set wins over a same-cycle clear
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= '0;
      mask_r   <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (mask_wr) begin
        mask_r <= pwdata[ivf_pkg::EV_W-1:0];
      end
      irq_r <= |(status_nxt & (mask_wr ?
                               pwdata[ivf_pkg::EV_W-1:0] : mask_r));
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign conv_req           = conv_req_r;
  assign vector_address_bus = vab_r;
  assign vab_valid          = vab_valid_r;
  assign vab_src            = vab_src_r;
  assign irq                = irq_r;

endmodule : ivf_vector_ctrl

// ==== ivf_vector_ctrl_asserts.sv ====
`timescale 1ns/1ps
module ivf_vector_ctrl_chk (
  input wire logic                         sys_clk,
  input wire logic                         resetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic [ivf_pkg::DATA_W-1:0]   prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  input wire logic [ivf_pkg::CONV_NUM-1:0] conv_src_req,
  input wire ivf_pkg::ivf_conv_req_t [ivf_pkg::CONV_NUM-1:0] conv_req,
  input wire logic                         win_valid,
  input wire logic [ivf_pkg::VSEL_W-1:0]   win_vector,
  input wire logic [ivf_pkg::PRIO_W-1:0]   win_level,
  input wire logic [ivf_pkg::VAB_W-1:0]    vector_address_bus,
  input wire logic                         vab_valid,
  input wire ivf_pkg::ivf_src_t            vab_src
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence table_win_s;
    win_valid && win_level != ivf_pkg::LEVEL_TOP;
  endsequence
  property conv_p(int k);
    conv_req[k].valid |-> $past(conv_src_req[k]) && conv_req[k].level != 2'h3;
  endproperty
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_src_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ack_a: assert property (pslverr |-> pready)
    else $error("error outside access");
  rdata_idle_a: assert property (!pready |-> prdata == '0)
    else $error("read data outside access");
  table_addr_a: assert property (table_win_s |=> vab_src == ivf_pkg::SRC_TABLE
    && vector_address_bus[7:0] == {$past(win_vector), 1'b0})
    else $error("table address low bits wrong");
  vab_idle_a: assert property (!win_valid |=> !vab_valid && vector_address_bus == '0
    && vab_src == ivf_pkg::SRC_NONE)
    else $error("vector bus not idle");
  fast_level_a: assert property (vab_src inside {ivf_pkg::SRC_FAST0, ivf_pkg::SRC_FAST1}
    |-> $past(win_valid && win_level == ivf_pkg::LEVEL_TOP))
    else $error("fast address below top level");
  for (genvar k = 0; k < ivf_pkg::CONV_NUM; k++) begin : g_conv
    conv_follow_a: assert property (conv_p(k))
      else $error("converter request level wrong");
  end
endmodule : ivf_vector_ctrl_chk
bind ivf_vector_ctrl ivf_vector_ctrl_chk u_chk (
  .sys_clk, .resetn, .psel, .penable, .prdata, .pready, .pslverr, .conv_src_req,
  .conv_req, .win_valid, .win_vector, .win_level, .vector_address_bus, .vab_valid, .vab_src
);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  conv_src_req = 4'h0;
  ivf_pkg::ivf_conv_req_t [3:0] conv_req;
  logic [ivf_pkg::VEC_LAST:ivf_pkg::VEC_FIRST] irq_req = '0;
  logic        win_valid;
  logic [6:0]  win_vector;
  logic [1:0]  win_level;
  logic [20:0] vector_address_bus;
  logic        vab_valid;
  ivf_pkg::ivf_src_t vab_src;
  logic        irq;
  int          bad_count = 0;
  int          compares = 0;
  logic [31:0] rd;
  logic        err;
  logic [20:0] va;
  ivf_pkg::ivf_src_t vs;
  logic [31:0] msk [8] = '{32'hff, 32'h1fff, 32'h7f, 32'hffff, 32'h1f, 32'h7f, 32'hffff, 32'h1f};
  logic [31:0] cfg [7] = '{32'h1abc, 32'h14, 32'h1234, 32'h15, 32'h1e, 32'h5678, 32'h0a};
  int          pv  [8] = '{2, 16, 17, 32, 33, 48, 49, 81};
  logic [1:0]  fq  [5] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h1};
  logic [6:0]  vv  [5] = '{7'h05, 7'h28, 7'h28, 7'h28, 7'h03};
  logic [1:0]  lv  [5] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
  logic [20:0] ve  [5] = '{21'h1abc0a, 21'h151234, 21'h0a5678, 21'h1abc50, 21'h1abc06};
  ivf_pkg::ivf_src_t se [5] = '{ivf_pkg::SRC_TABLE, ivf_pkg::SRC_FAST0,
                                ivf_pkg::SRC_FAST1, ivf_pkg::SRC_TABLE, ivf_pkg::SRC_TABLE};
  ivf_vector_ctrl uut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .conv_src_req, .conv_req, .irq_req, .win_valid,
    .win_vector, .win_level, .vector_address_bus, .vab_valid, .vab_src, .irq);
  ivf_core_model u_core (.sys_clk, .vector_address_bus, .vab_src, .win_valid,
    .win_vector, .win_level);
  always #20 sys_clk = ~sys_clk;
  task automatic end_sim();
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", pready, 1);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk("irq", irq, v);
    if (irq !== v) end_sim();
  endtask : wait_irq
  function automatic logic [31:0] exp_pend(input int k);
    logic [31:0] e;
    int v;
    e = 32'h0;
    for (int i = 0; i < 16; i++) begin
      v = 16 * k + 1 + i;
      e[i] = 1'b1;
      if (v >= ivf_pkg::VEC_FIRST && v <= ivf_pkg::VEC_LAST) e[i] = ~irq_req[v];
    end
    return e;
  endfunction : exp_pend
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, 10'(ivf_pkg::IDX_PRIO9 + k), 32'h0);
      chk("reset value", rd, 32'h0);
      xfer(1'b1, 10'(ivf_pkg::IDX_PRIO9 + k), 32'hffffffff);
      xfer(1'b0, 10'(ivf_pkg::IDX_PRIO9 + k), 32'h0);
      chk("field mask", rd, msk[k]);
    end
    xfer(1'b0, 10'h3ff, 32'h0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 32'h0);
    xfer(1'b1, ivf_pkg::IDX_PRIO9, 32'h6c);
    conv_src_req <= 4'hf;
    repeat (3) @(posedge sys_clk);
    chk("conv levels", conv_req[3:1], 9'b100_101_110);
    chk("conv disabled", conv_req[0].valid, 0);
    conv_src_req <= 4'h7;
    repeat (2) @(posedge sys_clk);
    chk("conv withdrawn", conv_req[3].valid, 0);
    foreach (pv[j]) irq_req[pv[j]] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 6; k++) begin
      xfer(1'b0, 10'(ivf_pkg::IDX_PEND0 + k), 32'h0);
      chk("pending", rd, exp_pend(k));
    end
    xfer(1'b1, ivf_pkg::IDX_PEND0, 32'h0);
    xfer(1'b0, ivf_pkg::IDX_PEND0, 32'h0);
    chk("pending write", rd, exp_pend(0));
    irq_req <= '0;
    repeat (2) @(posedge sys_clk);
    xfer(1'b0, ivf_pkg::IDX_PEND0 + 10'h2, 32'h0);
    chk("pending clear", rd, 32'hffff);
    for (int k = 0; k < 7; k++) xfer(1'b1, 10'(ivf_pkg::IDX_VBASE + k), cfg[k]);
    for (int c = 0; c < 5; c++) begin
      irq_req[20] <= fq[c][0];
      irq_req[30] <= fq[c][1];
      @(posedge sys_clk);
      u_core.take(vv[c], lv[c], c % 2, va, vs);
      chk("vector address", va, ve[c]);
      chk("vector source", vs, se[c]);
      chk("vector valid", vab_valid, 1);
    end
    u_core.idle();
    repeat (3) @(posedge sys_clk);
    chk("vector idle valid", vab_valid, 0);
    chk("vector idle bus", vector_address_bus, 0);
    xfer(1'b0, ivf_pkg::IDX_STAT, 32'h0);
    chk("status", rd, 32'h7);
    chk("irq masked", irq, 0);
    xfer(1'b1, ivf_pkg::IDX_MASK, 32'h7);
    wait_irq(1'b1);
    xfer(1'b1, ivf_pkg::IDX_STAT, 32'h7);
    wait_irq(1'b0);
    xfer(1'b0, ivf_pkg::IDX_STAT, 32'h0);
    chk("status cleared", rd, 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("conv after reset", conv_req, 12'h000);
    xfer(1'b0, ivf_pkg::IDX_PRIO9, 32'h0);
    chk("prio after reset", rd, 32'h0);
    xfer(1'b0, ivf_pkg::IDX_VBASE, 32'h0);
    chk("base after reset", rd, 32'h0);
    end_sim();
  end
endmodule : tb
